// ---- src/pfs_pkg.sv ----
`default_nettype none
package pfs_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] PFS_PA_DATA_ADDR = 32'hffff8380;
  localparam logic [31:0] PFS_PA_DIR_ADDR  = 32'hffff8384;
  localparam logic [31:0] PFS_PE_DATA_ADDR = 32'hffff83b0;
  localparam logic [31:0] PFS_PE_DIR_ADDR  = 32'hffff83b4;
  localparam logic [31:0] PFS_PE_FSEL_ADDR = 32'hffff83ba;

  // ==========================================================
  // Writable bit masks
  localparam logic [15:0] PFS_PA_MASK   = 16'h000c;
  localparam logic [15:0] PFS_PE_MASK   = 16'h70f5;
  localparam logic [15:0] PFS_FSEL_MASK = 16'h5511;

  // ==========================================================
  // Reset values
  localparam logic [15:0] PFS_PA_DIR_RST  = 16'h0000;
  localparam logic [15:0] PFS_PE_DIR_RST  = 16'h0000;
  localparam logic [15:0] PFS_FSEL_RST    = 16'h0000;
  localparam logic [15:0] PFS_PA_DATA_RST = 16'h0000;
  localparam logic [15:0] PFS_PE_DATA_RST = 16'h0000;

  // ==========================================================
  // Field positions
  localparam int PFS_PA_LO_BIT = 2;
  localparam int PFS_FN_PINS   = 6;
  // Port E pin index of each timer channel signal (0A,0C,1A,1B,2A,2B)
  localparam int PFS_FN_PIN [PFS_FN_PINS] = '{0, 2, 4, 5, 6, 7};
  // Function bit of pin n sits at bit 2*n
  localparam int PFS_FN_STRIDE = 2;

  // ==========================================================
  // Pin input filter depth
  localparam int PFS_SYNC_STAGES = 3;
endpackage
`default_nettype wire

// ---- src/pfs_pin_function_select.sv ----
// Chosen here: the strobed register port.
`default_nettype none
// How it works
// - After reset every multiplexed port E pin is a general-purpose input.
// - Port A direction bits 3 and 2 make their pins outputs; others read 0.
// - Port A direction register clears on reset, holds through sleep.
// - In general-purpose use, a port E direction bit 1 means output.
// - Port E direction: only bits 14,13,12,7,6,5,4,2,0 writable.
// - Port E direction register clears on reset, holds through sleep.
// - Function-select clears on reset to general I/O; holds through sleep.
// - Function-select reserved bits read zero; software writes zero.
// - Function bit 14 gives port E pin 7 to timer channel 2 B.
// - Function bit 12 gives port E pin 6 to timer channel 2 A.
// - Function bit 10 gives port E pin 5 to timer channel 1 B.
// - Function bit 8 gives port E pin 4 to timer channel 1 A.
// - Function bit 4 gives port E pin 2 to timer channel 0 C.
// - Function bit 0 gives port E pin 0 to timer channel 0 A.
// - All three control registers take byte and 16-bit accesses.
// - Data read returns pin level for inputs, stored value for outputs.
module pfs_pin_function_select
  import pfs_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              clock,        // System clock, 100 MHz
  input  wire logic              rst_b,        // Power-on reset, async
  input  wire logic              clk_en,       // Freezes all state when low
  input  wire logic [ADDR_W-1:0] bus_addr,     // Byte address
  input  wire logic [15:0]       bus_wdata,    // Write data
  input  wire logic [1:0]        bus_be,       // Lane enables, 1: [15:8]
  input  wire logic              bus_wr,       // Write strobe
  input  wire logic              bus_rd,       // Read strobe
  output logic      [15:0]       bus_rdata,    // Read data, next cycle
  input  wire logic [1:0]        pa_pin_in,    // Port A pins 3:2 level
  output logic      [1:0]        pa_pin_out,   // Port A pin drive value
  output logic      [1:0]        pa_pin_oe_b,  // Port A drive enable
  input  wire logic [15:0]       pe_pin_in,    // Port E pin level
  output logic      [15:0]       pe_pin_out,   // Port E pin drive value
  output logic      [15:0]       pe_pin_oe_b,  // Port E drive enable
  input  wire logic [5:0]        tmr_out,      // Timer signal value
  input  wire logic [5:0]        tmr_oe,       // Timer drive request
  output logic      [5:0]        tmr_in        // Filtered pin to timer
);

  // ==========================================================
  // Elaboration checks
  if (ADDR_W != 32) begin : g_bad_addr
    $error("pfs: ADDR_W must be 32");
  end

  // ==========================================================
  // Helpers
  function automatic logic [15:0] pfs_merge(
    input logic [15:0] old_v,
    input logic [15:0] wd,
    input logic [1:0]  be,
    input logic [15:0] mask
  );
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}};
    return ((wd & lane) | (old_v & ~lane)) & mask;
  endfunction

  function automatic logic [15:0] pfs_filter(
    input logic [15:0] held,
    input logic [15:0] s2,
    input logic [15:0] s3
  );
    return (s2 & s3) | (held & (s2 ^ s3));
  endfunction

  // ==========================================================
  // Registers
  logic [15:0] pa_dir_reg;
  logic [15:0] pe_dir_reg;
  logic [15:0] fsel_reg;
  logic [15:0] pa_data_reg;
  logic [15:0] pe_data_reg;
  logic [15:0] rdata_reg;
  logic [15:0] pa_s1_reg, pa_s2_reg, pa_s3_reg, pa_lvl_reg;
  logic [15:0] pe_s1_reg, pe_s2_reg, pe_s3_reg, pe_lvl_reg;

  logic [15:0] pa_dir_next;
  logic [15:0] pe_dir_next;
  logic [15:0] fsel_next;
  logic [15:0] pa_data_next;
  logic [15:0] pe_data_next;
  logic [15:0] rdata_next;

  // ==========================================================
  // Address decode
  wire        addr_even   = ~bus_addr[0];
  wire        hit_pa_dir  = addr_even &&
                            bus_addr[31:1] == PFS_PA_DIR_ADDR[31:1];
  wire        hit_pe_dir  = addr_even &&
                            bus_addr[31:1] == PFS_PE_DIR_ADDR[31:1];
  wire        hit_fsel    = addr_even &&
                            bus_addr[31:1] == PFS_PE_FSEL_ADDR[31:1];
  wire        hit_pa_data = addr_even &&
                            bus_addr[31:1] == PFS_PA_DATA_ADDR[31:1];
  wire        hit_pe_data = addr_even &&
                            bus_addr[31:1] == PFS_PE_DATA_ADDR[31:1];

  // ==========================================================
  // Register write paths
  assign pa_dir_next  = (bus_wr && hit_pa_dir) ?
    pfs_merge(pa_dir_reg, bus_wdata, bus_be, PFS_PA_MASK) :
    pa_dir_reg;
  assign pe_dir_next  = (bus_wr && hit_pe_dir) ?
    pfs_merge(pe_dir_reg, bus_wdata, bus_be, PFS_PE_MASK) :
    pe_dir_reg;
  assign fsel_next    = (bus_wr && hit_fsel) ?
    pfs_merge(fsel_reg, bus_wdata, bus_be, PFS_FSEL_MASK) :
    fsel_reg;
  assign pa_data_next = (bus_wr && hit_pa_data) ?
    pfs_merge(pa_data_reg, bus_wdata, bus_be, PFS_PA_MASK) :
    pa_data_reg;
  assign pe_data_next = (bus_wr && hit_pe_data) ?
    pfs_merge(pe_data_reg, bus_wdata, bus_be, PFS_PE_MASK) :
    pe_data_reg;

  // ==========================================================
  // Pin function per port E bit
  logic [15:0] pe_fn_mask;
  always_comb begin
    pe_fn_mask = 16'h0000;
    for (int k = 0; k < PFS_FN_PINS; k++) begin
      pe_fn_mask[PFS_FN_PIN[k]] =
        fsel_reg[PFS_FN_STRIDE * PFS_FN_PIN[k]];
    end
  end

  // Timer drive spread onto port E bit positions
  logic [15:0] tmr_out_w;
  logic [15:0] tmr_oe_w;
  always_comb begin
    tmr_out_w = 16'h0000;
    tmr_oe_w  = 16'h0000;
    for (int k = 0; k < PFS_FN_PINS; k++) begin
      tmr_out_w[PFS_FN_PIN[k]] = tmr_out[k];
      tmr_oe_w[PFS_FN_PIN[k]]  = tmr_oe[k];
    end
  end

  // ==========================================================
  // Pin drive
  wire [15:0] pa_drv = pa_dir_reg & PFS_PA_MASK;
  wire [15:0] pe_gp_drv = pe_dir_reg & PFS_PE_MASK & ~pe_fn_mask;
  wire [15:0] pe_fn_drv = tmr_oe_w & pe_fn_mask;
  wire [15:0] pe_val = (pe_data_reg & ~pe_fn_mask) |
                       (tmr_out_w & pe_fn_mask);

  assign pa_pin_out  = pa_data_reg[PFS_PA_LO_BIT +: 2];
  assign pa_pin_oe_b = ~pa_drv[PFS_PA_LO_BIT +: 2];
  assign pe_pin_out  = pe_val & PFS_PE_MASK;
  assign pe_pin_oe_b = ~(pe_gp_drv | pe_fn_drv);

  // Timer sees the filtered pin level
  always_comb begin
    tmr_in = 6'h00;
    for (int k = 0; k < PFS_FN_PINS; k++) begin
      tmr_in[k] = pe_lvl_reg[PFS_FN_PIN[k]];
    end
  end

  // ==========================================================
  // Read path
  wire [15:0] pa_pin_w = {12'h000, pa_pin_in, 2'b00};
  wire [15:0] pa_rd = ((pa_dir_reg & pa_data_reg) |
                       (~pa_dir_reg & pa_lvl_reg)) & PFS_PA_MASK;
  wire [15:0] pe_rd = ((pe_dir_reg & pe_data_reg) |
                       (~pe_dir_reg & pe_lvl_reg)) & PFS_PE_MASK;

  assign rdata_next = !bus_rd     ? 16'h0000 :
                      hit_pa_dir  ? pa_dir_reg :
                      hit_pe_dir  ? pe_dir_reg :
                      hit_fsel    ? fsel_reg :
                      hit_pa_data ? pa_rd :
                      hit_pe_data ? pe_rd :
                      16'h0000;
  assign bus_rdata = rdata_reg;

  // ==========================================================
  // Control registers; no sleep input, so contents always hold
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pa_dir_reg  <= PFS_PA_DIR_RST;
      pe_dir_reg  <= PFS_PE_DIR_RST;
      fsel_reg    <= PFS_FSEL_RST;
      pa_data_reg <= PFS_PA_DATA_RST;
      pe_data_reg <= PFS_PE_DATA_RST;
      rdata_reg   <= 16'h0000;
    end else if (clk_en) begin
      pa_dir_reg  <= pa_dir_next;
      pe_dir_reg  <= pe_dir_next;
      fsel_reg    <= fsel_next;
      pa_data_reg <= pa_data_next;
      pe_data_reg <= pe_data_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ==========================================================
  // Pin input filter: three stages, change taken when last two agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pa_s1_reg  <= 16'h0000;
      pa_s2_reg  <= 16'h0000;
      pa_s3_reg  <= 16'h0000;
      pa_lvl_reg <= 16'h0000;
      pe_s1_reg  <= 16'h0000;
      pe_s2_reg  <= 16'h0000;
      pe_s3_reg  <= 16'h0000;
      pe_lvl_reg <= 16'h0000;
    end else if (clk_en) begin
      pa_s1_reg  <= pa_pin_w;
      pa_s2_reg  <= pa_s1_reg;
      pa_s3_reg  <= pa_s2_reg;
      pa_lvl_reg <= pfs_filter(pa_lvl_reg, pa_s2_reg, pa_s3_reg);
      pe_s1_reg  <= pe_pin_in;
      pe_s2_reg  <= pe_s1_reg;
      pe_s3_reg  <= pe_s2_reg;
      pe_lvl_reg <= pfs_filter(pe_lvl_reg, pe_s2_reg, pe_s3_reg);
    end
  end

endmodule
`default_nettype wire

// ---- verification/pfs_chk.sv ----
`default_nettype none
module pfs_chk
  import pfs_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic              clock,       // Clock
  input wire logic              rst_b,       // Reset
  input wire logic              clk_en,      // Enable
  input wire logic [ADDR_W-1:0] bus_addr,    // Address
  input wire logic [15:0]       bus_wdata,   // Write data
  input wire logic [1:0]        bus_be,      // Lanes
  input wire logic              bus_wr,      // Write
  input wire logic              bus_rd,      // Read
  input wire logic [15:0]       bus_rdata,   // Read data
  input wire logic [15:0]       pe_pin_in,   // E level
  input wire logic [15:0]       pe_pin_out,  // E value
  input wire logic [15:0]       pe_pin_oe_b, // E enable
  input wire logic [1:0]        pa_pin_oe_b, // A enable
  input wire logic [5:0]        tmr_out,     // Timer value
  input wire logic [5:0]        tmr_oe,      // Timer enable
  input wire logic [5:0]        tmr_in       // Timer input
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Request decodes
  wire wr_ok = bus_wr && clk_en;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence pa_dir_wr;
    wr_ok && bus_addr == PFS_PA_DIR_ADDR && bus_be[0];
  endsequence
  sequence pe_dir_wr;
    wr_ok && bus_addr == PFS_PE_DIR_ADDR && bus_be == 2'b11;
  endsequence
  sequence fsel_wr;
    wr_ok && bus_addr == PFS_PE_FSEL_ADDR && bus_be == 2'b11;
  endsequence
  sequence pin0_steady;
    (clk_en && $stable(pe_pin_in[0])) [*5];
  endsequence
  // ==========================================================
  // Checks
  reset_inputs_a: assert property (
    $rose(rst_b) |-> pe_pin_oe_b == 16'hffff && pa_pin_oe_b == 2'b11)
    else $error("pins not all inputs after reset");
  pa_dir_drive_a: assert property (
    pa_dir_wr |=> pa_pin_oe_b == ~$past(bus_wdata[3:2]))
    else $error("port A enable does not follow direction");
  pe_gp_drive_a: assert property (
    pe_dir_wr |=> pe_pin_oe_b[14:12] == ~$past(bus_wdata[14:12]))
    else $error("port E enable does not follow direction");
  unused_pins_a: assert property (
    (pe_pin_oe_b & ~PFS_PE_MASK) == ~PFS_PE_MASK)
    else $error("unused port E pin driven");
  fsel_reserved_a: assert property (
    bus_rd && clk_en && bus_addr == PFS_PE_FSEL_ADDR |=>
      (bus_rdata & ~PFS_FSEL_MASK) == 16'h0000)
    else $error("reserved function bits read nonzero");
  pin7_timer_a: assert property (
    fsel_wr ##0 bus_wdata[14] |=>
      pe_pin_out[7] == tmr_out[5] && pe_pin_oe_b[7] == ~tmr_oe[5])
    else $error("pin 7 not driven by timer");
  pin0_timer_a: assert property (
    fsel_wr ##0 bus_wdata[0] |=>
      pe_pin_out[0] == tmr_out[0] && pe_pin_oe_b[0] == ~tmr_oe[0])
    else $error("pin 0 not driven by timer");
  pin_filter_a: assert property (
    pin0_steady |-> tmr_in[0] == pe_pin_in[0])
    else $error("steady pin level not seen by timer");
endmodule
bind pfs_pin_function_select pfs_chk #(.ADDR_W(ADDR_W)) i_pfs_chk (
  .clock, .rst_b, .clk_en, .bus_addr, .bus_wdata, .bus_be, .bus_wr, .bus_rd,
  .bus_rdata, .pe_pin_in, .pe_pin_out, .pe_pin_oe_b, .pa_pin_oe_b, .tmr_out,
  .tmr_oe, .tmr_in
);
`default_nettype wire

// ---- verification/pfs_pin_model.sv ----
`default_nettype none
module pfs_pin_model (
  input  wire logic [15:0] pe_pin_out,  // E value
  input  wire logic [15:0] pe_pin_oe_b, // E enable
  input  wire logic [1:0]  pa_pin_out,  // A value
  input  wire logic [1:0]  pa_pin_oe_b, // A enable
  input  wire logic [15:0] pe_ext,      // E outside level
  input  wire logic [1:0]  pa_ext,      // A outside level
  output logic      [15:0] pe_pin_in,   // E wire level
  output logic      [1:0]  pa_pin_in    // A wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins show the device value, released ones the outside level
  assign pe_pin_in = (pe_pin_out & ~pe_pin_oe_b) | (pe_ext & pe_pin_oe_b);
  assign pa_pin_in = (pa_pin_out & ~pa_pin_oe_b) | (pa_ext & pa_pin_oe_b);
endmodule
`default_nettype wire

// ---- verification/test_port_pin_function_select.sv ----
`default_nettype none
module test_port_pin_function_select
  import pfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clock = 1'b0;
  logic             rst_b = 1'b0;
  logic             clk_en = 1'b1;
  logic [31:0]      bus_addr = 32'h0;
  logic [15:0]      bus_wdata = 16'h0;
  logic [1:0]       bus_be = 2'b11;
  logic             bus_wr = 1'b0;
  logic             bus_rd = 1'b0;
  logic [15:0]      pe_ext = 16'h0;
  logic [1:0]       pa_ext = 2'b0;
  logic [5:0]       tmr_out = 6'h0;
  logic [5:0]       tmr_oe = 6'h0;
  wire logic [15:0] bus_rdata, pe_pin_in, pe_pin_out, pe_pin_oe_b;
  wire logic [1:0]  pa_pin_in, pa_pin_out, pa_pin_oe_b;
  wire logic [5:0]  tmr_in;
  logic [15:0]      exp_q[$];
  logic [15:0]      v, eo, eb;
  logic             rd_q = 1'b0;
  int               err_total = 0;
  int               checked = 0;
  int               seed = 32'hdff8;
  always #5 clock = ~clock;
  pfs_pin_function_select #(.ADDR_W(32)) i_pfs_pin_function_select (
    .clock, .rst_b, .clk_en, .bus_addr, .bus_wdata, .bus_be, .bus_wr,
    .bus_rd, .bus_rdata, .pa_pin_in, .pa_pin_out, .pa_pin_oe_b, .pe_pin_in,
    .pe_pin_out, .pe_pin_oe_b, .tmr_out, .tmr_oe, .tmr_in
  );
  pfs_pin_model i_pfs_pin_model (
    .pe_pin_out, .pe_pin_oe_b, .pa_pin_out, .pa_pin_oe_b, .pe_ext, .pa_ext,
    .pe_pin_in, .pa_pin_in
  );
  // ==========================================================
  // Bus tasks and comparison
  task automatic chk(string name, logic [15:0] e, logic [15:0] got);
    checked++;
    if (got !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic wr(logic [31:0] a, logic [15:0] d, logic [1:0] be);
    bus_addr <= a;
    bus_wdata <= d;
    bus_be <= be;
    bus_wr <= 1'b1;
    bus_rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(logic [31:0] a, logic [15:0] e);
    exp_q.push_back(e);
    bus_addr <= a;
    bus_rd <= 1'b1;
    bus_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic idle();
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Read data monitor
  always @(posedge clock) rd_q <= bus_rd && clk_en;
  always @(negedge clock) begin
    if (rd_q && exp_q.size() > 0) begin
      chk("bus_rdata", exp_q.pop_front(), bus_rdata);
    end
  end
  initial begin
    repeat (2000) @(posedge clock);
    err_total++;
    final_report();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk("pe_pin_oe_b", 16'hffff, pe_pin_oe_b);
    chk("pa_pin_oe_b", 16'h0003, {14'h0, pa_pin_oe_b});
    rd(PFS_PA_DIR_ADDR, 16'h0000);
    rd(PFS_PE_DIR_ADDR, 16'h0000);
    rd(PFS_PE_FSEL_ADDR, 16'h0000);
    wr(PFS_PA_DIR_ADDR, 16'hffff, 2'b11);
    wr(PFS_PE_DIR_ADDR, 16'hffff, 2'b11);
    wr(PFS_PE_FSEL_ADDR, 16'hffff, 2'b11);
    rd(PFS_PA_DIR_ADDR, 16'h000c);
    rd(PFS_PE_DIR_ADDR, 16'h70f5);
    rd(PFS_PE_FSEL_ADDR, 16'h5511);
    rd(32'hffff83bc, 16'h0000);
    wr(PFS_PE_FSEL_ADDR, 16'h0000, 2'b11);
    wr(PFS_PE_FSEL_ADDR, 16'hffff, 2'b10);
    rd(PFS_PE_FSEL_ADDR, 16'h5500);
    wr(PFS_PE_DIR_ADDR, 16'h0000, 2'b01);
    rd(PFS_PE_DIR_ADDR, 16'h7000);
    clk_en <= 1'b0;
    wr(PFS_PA_DIR_ADDR, 16'h0000, 2'b11);
    clk_en <= 1'b1;
    rd(PFS_PA_DIR_ADDR, 16'h000c);
    v = 16'($random(seed));
    wr(PFS_PE_DIR_ADDR, 16'h70f5, 2'b11);
    wr(PFS_PE_DATA_ADDR, v, 2'b11);
    wr(PFS_PA_DATA_ADDR, v, 2'b11);
    for (int k = 0; k < PFS_FN_PINS; k++) begin
      tmr_out <= 6'($random(seed));
      tmr_oe <= 6'($random(seed));
      wr(PFS_PE_FSEL_ADDR, 16'h0001 << (2 * PFS_FN_PIN[k]), 2'b11);
      idle();
      eo = v & 16'h70f5;
      eb = 16'h8f0a;
      eo[PFS_FN_PIN[k]] = tmr_out[k];
      eb[PFS_FN_PIN[k]] = ~tmr_oe[k];
      chk("pe_pin_out", eo, pe_pin_out);
      chk("pe_pin_oe_b", eb, pe_pin_oe_b);
    end
    chk("pa_pin_out", {14'h0, v[3:2]}, {14'h0, pa_pin_out});
    chk("pa_pin_oe_b", 16'h0000, {14'h0, pa_pin_oe_b});
    rd(PFS_PE_DATA_ADDR, v & 16'h70f5);
    wr(PFS_PE_FSEL_ADDR, 16'h0000, 2'b11);
    pe_ext <= 16'($random(seed));
    wr(PFS_PE_DIR_ADDR, 16'h0000, 2'b11);
    repeat (6) idle();
    rd(PFS_PE_DATA_ADDR, pe_ext & 16'h70f5);
    chk("tmr_in", {10'h000, pe_ext[7:4], pe_ext[2], pe_ext[0]},
        {10'h000, tmr_in});
    rd(PFS_PA_DATA_ADDR, v & 16'h000c);
    pa_ext <= 2'($random(seed));
    wr(PFS_PA_DIR_ADDR, 16'h0000, 2'b11);
    repeat (6) idle();
    rd(PFS_PA_DATA_ADDR, {12'h000, pa_ext, 2'b00});
    repeat (2) idle();
    final_report();
  end
endmodule
`default_nettype wire
